// [rtl/bst_defines.svh]
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_IR_W        4
`define BST_OP_EXTEST   4'h0
`define BST_OP_SAMPLE   4'h1
`define BST_OP_IDCODE   4'h2
`define BST_OP_HIGHZ    4'h3
`define BST_OP_BYPASS   4'hf
`define BST_IR_CAPTURE  4'h1
`define BST_ID_W        32
`define BST_CELL_BITS   3
`define BST_PIN_SYNC_RST 4'h8
`define BST_TCK_IDLE    1'b1
`define BST_TCK_PERIOD_NS 400
`define BST_CLK_PERIOD_NS 50

`endif

// [rtl/bst_pkg.sv]
`include "bst_defines.svh"

package bst_pkg;

    typedef enum logic [15:0] {
        ST_RESET  = 16'h0001,
        ST_IDLE   = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR  = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR  = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UP_DR  = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR  = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UP_IR  = 16'h8000
    } bst_tap_e;

    typedef enum logic [4:0] {
        IN_EXTEST = 5'h01,
        IN_SAMPLE = 5'h02,
        IN_IDCODE = 5'h04,
        IN_HIGHZ  = 5'h08,
        IN_BYPASS = 5'h10
    } bst_instr_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic tdo;
    } bst_jpins_s;

endpackage

// [rtl/bst_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module bst_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        wr_d  = push ? ptr_inc(wr_q) : wr_q;
        rd_d  = pop ? ptr_inc(rd_q) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW + 1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW + 1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

endmodule

`default_nettype wire

// [rtl/bst_tap_port.sv]
`timescale 1ns/1ps
`default_nettype none

`include "bst_defines.svh"

// Operation
// - Without a test-reset pin, power-up reset forces the controller to reset.
// - Decode SAMPLE/PRELOAD, EXTEST, BYPASS, IDCODE and HIGHZ; others act as BYPASS.
// - Every dedicated input and I/O pin owns its own scan cell.
// - Cells chain through capture stages from TDI to TDO.
// - With the test port disabled its four pins work as general-purpose I/O.
// - Each cell has three capture stages and two update stages.
// - Capture samples live signals, shift moves serially, update loads update stages.
// - Two cell kinds: pin cells and macrocell cells.
// - Capture, shift and update strobes come from the internal controller only.
// - Reprogramming runs over the four test pins with standard protocol, TTL levels.
module bst_tap_port
    import bst_pkg::*;
#(
    parameter int             NPIN       = 72,
    parameter int             NMC        = 64,
    parameter int             FIFO_DEPTH = 4,
    parameter logic [31:0]    IDCODE     = 32'h0000_0001 // Arbitrary identity value.
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            jtag_en,
    input  wire bst_jpins_s      jp_i,
    output bst_jpins_s           jp_o,
    output bst_jpins_s           jp_oe,
    input  wire bst_jpins_s      gp_o,
    input  wire bst_jpins_s      gp_oe,
    output bst_jpins_s           gp_i,
    input  wire logic [NPIN-1:0] pad_i,
    input  wire logic [NPIN-1:0] core_out,
    input  wire logic [NPIN-1:0] core_oe,
    output logic [NPIN-1:0]      pad_o,
    output logic [NPIN-1:0]      pad_oe,
    output logic [NPIN-1:0]      core_in,
    input  wire logic [NMC-1:0]  mc_q,
    input  wire logic [NMC-1:0]  mc_fb,
    input  wire logic [NMC-1:0]  mc_oe,
    output logic                 mc_ovr_en,
    output logic [NMC-1:0]       mc_ovr_val,
    output logic [NMC-1:0]       mc_ovr_oe,
    output logic                 snap_valid,
    input  wire logic            snap_ready,
    output logic [NPIN-1:0]      snap_data
);
    localparam int NCELL = NPIN + NMC;
    localparam int CB    = `BST_CELL_BITS;
    localparam int L     = CB * NCELL;
    localparam int IRW   = `BST_IR_W;
    localparam int IDW   = `BST_ID_W;

    function automatic bst_tap_e tap_next(input bst_tap_e s, input logic tms);
        unique case (s)
            ST_RESET:  tap_next = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  tap_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: tap_next = tms ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_next = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  tap_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: tap_next = tms ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  tap_next = tms ? ST_SEL_DR : ST_IDLE;
            default:   tap_next = ST_RESET;
        endcase
    endfunction

    function automatic bst_instr_e decode(input logic [IRW-1:0] op);
        unique case (op)
            `BST_OP_EXTEST: decode = IN_EXTEST;
            `BST_OP_SAMPLE: decode = IN_SAMPLE;
            `BST_OP_IDCODE: decode = IN_IDCODE;
            `BST_OP_HIGHZ:  decode = IN_HIGHZ;
            default:        decode = IN_BYPASS;
        endcase
    endfunction

    bst_jpins_s      jp_s1_q, jp_s2_q;
    logic            tck_s3_q;
    logic [NPIN-1:0] pad_s1_q, pad_s2_q;
    logic            rise, fall, tdi, tms;

    bst_tap_e        state_q, state_d;
    bst_instr_e      ir_q, ir_d;
    logic [IRW-1:0]  ir_sh_q, ir_sh_d;
    logic [L-1:0]    chain_q, chain_d, cap_vec;
    logic [NCELL-1:0] upd_out_q, upd_out_d, upd_oe_q, upd_oe_d;
    logic            byp_q, byp_d;
    logic [IDW-1:0]  id_q, id_d;
    logic            tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic [NPIN-1:0] pad_o_q, pad_o_d, pad_oe_q, pad_oe_d;
    logic [NPIN-1:0] snap_word;
    logic            bnd_sel, push, fifo_ready;

    assign rise    = jp_s2_q.tck & ~tck_s3_q;
    assign fall    = ~jp_s2_q.tck & tck_s3_q;
    assign tdi     = jp_s2_q.tdi;
    assign tms     = jp_s2_q.tms;
    assign bnd_sel = (ir_q == IN_EXTEST) || (ir_q == IN_SAMPLE);

    // Pin cells observe pad, core data and core enable; macrocell cells observe output,
    // feedback and enable.
    always_comb begin
        cap_vec = '0;
        for (int i = 0; i < NPIN; i++) begin
            cap_vec[CB*i +: CB] = {core_oe[i], core_out[i], pad_s2_q[i]};
        end
        for (int j = 0; j < NMC; j++) begin
            cap_vec[CB*(NPIN+j) +: CB] = {mc_oe[j], mc_fb[j], mc_q[j]};
        end
        snap_word = '0;
        for (int i = 0; i < NPIN; i++) begin
            snap_word[i] = chain_q[CB*i+1];
        end
    end

    assign push = fall && (state_q == ST_UP_DR) && bnd_sel;

    always_comb begin
        state_d   = state_q;
        ir_d      = ir_q;
        ir_sh_d   = ir_sh_q;
        chain_d   = chain_q;
        upd_out_d = upd_out_q;
        upd_oe_d  = upd_oe_q;
        byp_d     = byp_q;
        id_d      = id_q;
        tdo_d     = tdo_q;
        tdo_oe_d  = tdo_oe_q;
        if (!jtag_en) begin
            state_d  = ST_RESET;
            ir_d     = IN_IDCODE;
            tdo_oe_d = 1'b0;
        end else if (rise) begin
            state_d = tap_next(state_q, tms);
            if (state_q == ST_CAP_DR) begin
                if (bnd_sel) begin
                    chain_d = cap_vec;
                end
                byp_d = 1'b0;
                id_d  = IDCODE;
            end
            if (state_q == ST_SH_DR) begin
                if (bnd_sel) begin
                    chain_d = {tdi, chain_q[L-1:1]};
                end
                byp_d = tdi;
                id_d  = {tdi, id_q[IDW-1:1]};
            end
            if (state_q == ST_CAP_IR) begin
                ir_sh_d = `BST_IR_CAPTURE;
            end
            if (state_q == ST_SH_IR) begin
                ir_sh_d = {tdi, ir_sh_q[IRW-1:1]};
            end
        end else if (fall) begin
            tdo_oe_d = (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
            if (state_q == ST_SH_IR) begin
                tdo_d = ir_sh_q[0];
            end else if (bnd_sel) begin
                tdo_d = chain_q[0];
            end else if (ir_q == IN_IDCODE) begin
                tdo_d = id_q[0];
            end else begin
                tdo_d = byp_q;
            end
            if (state_q == ST_RESET) begin
                ir_d = IN_IDCODE;
            end
            if (state_q == ST_UP_IR) begin
                ir_d = decode(ir_sh_q);
            end
            if (state_q == ST_UP_DR && bnd_sel) begin
                for (int c = 0; c < NCELL; c++) begin
                    upd_out_d[c] = chain_q[CB*c+1];
                    upd_oe_d[c]  = chain_q[CB*c+2];
                end
            end
        end
        for (int i = 0; i < NPIN; i++) begin
            pad_o_d[i]  = (ir_q == IN_EXTEST) ? upd_out_q[i] : core_out[i];
            pad_oe_d[i] = (ir_q == IN_EXTEST) ? upd_oe_q[i] : core_oe[i];
        end
        if (ir_q == IN_HIGHZ) begin
            pad_oe_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            // The clock stages start at the idle-high level so no false rise follows reset.
            jp_s1_q  <= bst_jpins_s'(`BST_PIN_SYNC_RST);
            jp_s2_q  <= bst_jpins_s'(`BST_PIN_SYNC_RST);
            tck_s3_q <= `BST_TCK_IDLE;
            pad_s1_q <= '0;
            pad_s2_q <= '0;
        end else begin
            jp_s1_q  <= jp_i;
            jp_s2_q  <= jp_s1_q;
            tck_s3_q <= jp_s2_q.tck;
            pad_s1_q <= pad_i;
            pad_s2_q <= pad_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q   <= ST_RESET;
            ir_q      <= IN_IDCODE;
            ir_sh_q   <= '0;
            chain_q   <= '0;
            upd_out_q <= '0;
            upd_oe_q  <= '0;
            byp_q     <= 1'b0;
            id_q      <= '0;
            tdo_q     <= 1'b0;
            tdo_oe_q  <= 1'b0;
            pad_o_q   <= '0;
            pad_oe_q  <= '0;
        end else begin
            state_q   <= state_d;
            ir_q      <= ir_d;
            ir_sh_q   <= ir_sh_d;
            chain_q   <= chain_d;
            upd_out_q <= upd_out_d;
            upd_oe_q  <= upd_oe_d;
            byp_q     <= byp_d;
            id_q      <= id_d;
            tdo_q     <= tdo_d;
            tdo_oe_q  <= tdo_oe_d;
            pad_o_q   <= pad_o_d;
            pad_oe_q  <= pad_oe_d;
        end
    end

    // Updated pin words stream out for programming and observation; a full buffer drops them.
    bst_fifo #(
        .W     (NPIN),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (snap_word),
        .out_valid (snap_valid),
        .out_ready (snap_ready),
        .out_data  (snap_data)
    );

    assign jp_o       = jtag_en ? bst_jpins_s'({3'b000, tdo_q}) : gp_o;
    assign jp_oe      = jtag_en ? bst_jpins_s'({3'b000, tdo_oe_q}) : gp_oe;
    assign gp_i       = jp_s2_q;
    assign pad_o      = pad_o_q;
    assign pad_oe     = pad_oe_q;
    assign core_in    = pad_s2_q;
    assign mc_ovr_en  = (ir_q == IN_EXTEST);
    assign mc_ovr_val = upd_out_q[NCELL-1:NPIN];
    assign mc_ovr_oe  = upd_oe_q[NCELL-1:NPIN];

endmodule

`default_nettype wire

// [verif/bst_tap_props.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_tap_props
    import bst_pkg::*;
#(
    parameter int NPIN = 72
) (
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            jtag_en,
    input wire bst_jpins_s      jp_i,
    input wire bst_jpins_s      jp_o,
    input wire bst_jpins_s      jp_oe,
    input wire bst_jpins_s      gp_o,
    input wire bst_jpins_s      gp_oe,
    input wire bst_jpins_s      gp_i,
    input wire logic [NPIN-1:0] core_oe,
    input wire logic [NPIN-1:0] pad_oe,
    input wire logic            mc_ovr_en,
    input wire logic            snap_valid,
    input wire logic            snap_ready,
    input wire logic [NPIN-1:0] snap_data
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_rst;
        jtag_en && $rose(resetn) |-> !jp_oe.tdo && !mc_ovr_en;
    endproperty
    a_rst: assert property (p_rst) else $error("Port not idle after reset.");
    property p_gpo;
        !jtag_en |-> jp_o == gp_o && jp_oe == gp_oe;
    endproperty
    a_gpo: assert property (p_gpo) else $error("Pins do not follow core drive.");
    property p_gpi;
        $stable(jp_i) [*4] |=> gp_i == $past(jp_i);
    endproperty
    a_gpi: assert property (p_gpi) else $error("Pin levels not passed to core.");
    property p_only_tdo;
        jtag_en |-> jp_oe[3:1] == 3'h0 && jp_o[3:1] == 3'h0;
    endproperty
    a_only_tdo: assert property (p_only_tdo) else $error("Input pin driven.");
    property p_tdo_fall;
        jtag_en && $past(jtag_en) && $changed(jp_o.tdo) |-> !$past(jp_i.tck, 3);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("Data out moved off fall.");
    property p_oe_fall;
        jtag_en && $past(jtag_en) && $changed(jp_oe.tdo) |-> !$past(jp_i.tck, 3);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("Enable moved off fall.");
    property p_snap;
        snap_valid && !snap_ready |=> snap_valid && $stable(snap_data);
    endproperty
    a_snap: assert property (p_snap) else $error("Snapshot not held.");
    property p_pad;
        !mc_ovr_en && !$past(mc_ovr_en) |-> pad_oe == $past(core_oe) || pad_oe == '0;
    endproperty
    a_pad: assert property (p_pad) else $error("Pad enable not from core.");
    c_shift: cover property (jtag_en && $rose(jp_oe.tdo));
    c_snap: cover property (snap_valid && snap_ready);
    c_extest: cover property (mc_ovr_en);
    c_gpio: cover property (!jtag_en && jp_oe.tdo);
endmodule
bind bst_tap_port bst_tap_props #(.NPIN(NPIN)) u_props (
    .clk(clk), .resetn(resetn), .jtag_en(jtag_en), .jp_i(jp_i), .jp_o(jp_o), .jp_oe(jp_oe),
    .gp_o(gp_o), .gp_oe(gp_oe), .gp_i(gp_i), .core_oe(core_oe), .pad_oe(pad_oe),
    .mc_ovr_en(mc_ovr_en), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data)
);
`default_nettype wire

// [verif/bst_jtag_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_tester (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo_d,
    input wire logic tdo_oe,
    output logic     tdo_w
);
    logic last = 1'b0;
    always @(tdo_d or tdo_oe) if (tdo_oe) last = tdo_d;
    // A released line shows the inverse of its last driven value.
    assign tdo_w = tdo_oe ? tdo_d : ~last;
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Mode and data change at the fall; the clock stands high between frames.
    task automatic step(input logic m, input logic di, output logic o);
        tck = 1'b0;
        tms = m;
        tdi = di;
        #200 tck = 1'b1;
        #190 o = tdo_w;
        #10;
    endtask
    // Instruction scan from idle back to idle.
    task automatic run_ir(input logic [3:0] op, output logic [3:0] cap);
        logic o;
        #13;
        step(1'b1, 1'b1, o);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < 4; i++) step(i == 3, op[i], cap[i]);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    // Data scan of n bits from idle back to idle.
    task automatic run_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        #13;
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

// [verif/bst_tap_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bst_tap_port_bench
    import bst_pkg::*;
    ;
    localparam int          NP  = 4;
    localparam int          NM  = 2;
    localparam int          L   = 3 * (NP + NM);
    localparam logic [31:0] IDV = 32'h0a5c_3e71; // Arbitrary identity value.
    logic            clk, resetn, jtag_en, snap_ready, snap_valid, mc_ovr_en;
    logic            tck_t, tms_t, tdi_t, tdo_w;
    bst_jpins_s      jp_i, jp_o, jp_oe, gp_o, gp_oe, gp_i;
    logic [NP-1:0]   pad_i, core_out, core_oe, pad_o, pad_oe, core_in, snap_data, pre;
    logic [NM-1:0]   mc_q, mc_fb, mc_oe, mc_ovr_val, mc_ovr_oe;
    logic [31:0]     d;
    logic [3:0]      c;
    logic [31:0]     exq[$];
    int              err_total = 0;
    int              checks = 0;
    assign jp_i = (jp_oe & jp_o) | (~jp_oe & {tck_t, tms_t, tdi_t, tdo_w});
    bst_tap_port #(.NPIN(NP), .NMC(NM), .IDCODE(IDV)) dut (
        .clk(clk), .resetn(resetn), .jtag_en(jtag_en), .jp_i(jp_i), .jp_o(jp_o),
        .jp_oe(jp_oe), .gp_o(gp_o), .gp_oe(gp_oe), .gp_i(gp_i), .pad_i(pad_i),
        .core_out(core_out), .core_oe(core_oe), .pad_o(pad_o), .pad_oe(pad_oe),
        .core_in(core_in), .mc_q(mc_q), .mc_fb(mc_fb), .mc_oe(mc_oe),
        .mc_ovr_en(mc_ovr_en), .mc_ovr_val(mc_ovr_val), .mc_ovr_oe(mc_ovr_oe),
        .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data)
    );
    bst_jtag_tester u_tst (.tck(tck_t), .tms(tms_t), .tdi(tdi_t), .tdo_d(jp_o.tdo),
                           .tdo_oe(jp_oe.tdo), .tdo_w(tdo_w));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [L-1:0] capv();
        logic [L-1:0] v;
        for (int i = 0; i < NP; i++) v[3*i+:3] = {core_oe[i], core_out[i], pad_i[i]};
        for (int i = 0; i < NM; i++) v[3*(NP+i)+:3] = {mc_oe[i], mc_fb[i], mc_q[i]};
        return v;
    endfunction
    function automatic logic [31:0] fld(input logic [L-1:0] p, input int k, b, n);
        fld = '0;
        for (int i = 0; i < n; i++) fld[i] = p[3*(b+i)+k];
    endfunction
    task automatic t_idcode();
        #13;
        u_tst.step(1'b0, 1'b1, c[0]);
        u_tst.run_dr(32, 32'h0, d);
        chk("idcode", IDV, d);
        chk("tdo_oe_idle", 32'h0, 32'(jp_oe.tdo));
    endtask
    task automatic t_bypass(input logic [3:0] op);
        u_tst.run_ir(op, c);
        chk("ir_capture", 32'h1, 32'(c));
        u_tst.run_dr(3, 32'h5, d);
        chk("bypass", 32'h2, d);
    endtask
    task automatic t_sample();
        logic [L-1:0] p;
        u_tst.run_ir(4'h1, c);
        for (int k = 0; k < 5; k++) begin
            p = 18'(32'h2aaa5 + 32'h492 * k);
            u_tst.run_dr(L, 32'(p), d);
            chk("capture", 32'(capv()), d);
            if (k < 4) exq.push_back(fld(p, 1, 0, NP));
        end
        pre = 4'(fld(p, 1, 0, NP));
        repeat (4) begin
            @(negedge clk);
            chk("snap_data", exq.pop_front(), 32'(snap_data));
            @(posedge clk) snap_ready <= 1'b1;
            @(posedge clk) snap_ready <= 1'b0;
            repeat (2) @(posedge clk);
        end
        @(negedge clk);
        chk("snap_empty", 32'h0, 32'(snap_valid));
    endtask
    task automatic t_extest();
        logic [L-1:0] q;
        q = 18'h1c6b3;
        u_tst.run_ir(4'h0, c);
        chk("preload", 32'(pre), 32'(pad_o));
        u_tst.run_dr(L, 32'(q), d);
        chk("pad_o", fld(q, 1, 0, NP), 32'(pad_o));
        chk("pad_oe", fld(q, 2, 0, NP), 32'(pad_oe));
        chk("mc_ovr_oe", fld(q, 2, NP, NM), 32'(mc_ovr_oe));
        chk("mc_ovr_val", fld(q, 1, NP, NM), 32'(mc_ovr_val));
        chk("mc_ovr_en", 32'h1, 32'(mc_ovr_en));
    endtask
    task automatic t_highz();
        u_tst.run_ir(4'h3, c);
        chk("highz_oe", 32'h0, 32'(pad_oe));
        u_tst.run_ir(4'h2, c);
        chk("core_oe", 32'hf, 32'(pad_oe));
        u_tst.run_dr(32, 32'h0, d);
        chk("idcode_ir", IDV, d);
    endtask
    task automatic t_gpio();
        @(posedge clk) jtag_en <= 1'b0;
        gp_o <= 4'ha;
        gp_oe <= 4'h1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("jp_o", 32'ha, 32'(jp_o));
        chk("jp_oe", 32'h1, 32'(jp_oe));
        chk("gp_i", 32'({tck_t, tms_t, tdi_t, 1'b0}), 32'(gp_i));
    endtask
    initial begin
        #2_000_000;
        err_total++;
        give_verdict();
    end
    initial begin
        resetn <= 1'b0;
        jtag_en <= 1'b1;
        snap_ready <= 1'b0;
        gp_o <= '0;
        gp_oe <= '0;
        pad_i <= 4'h9;
        core_out <= 4'h6;
        core_oe <= 4'hf;
        mc_q <= 2'h1;
        mc_fb <= 2'h2;
        mc_oe <= 2'h3;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("core_in", 32'h9, 32'(core_in));
        t_idcode();
        t_bypass(4'hf);
        t_bypass(4'h7);
        t_sample();
        t_extest();
        t_highz();
        u_tst.run_ir(4'hf, c);
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_idcode();
        t_gpio();
        give_verdict();
    end
endmodule
`default_nettype wire
